// ==== pkg/serial_map.svh ====
`ifndef SERIAL_MAP_SVH
`define SERIAL_MAP_SVH

// Register byte offsets
`define OFS_RX_BUF      8'h00
`define OFS_INT_EN      8'h04
`define OFS_LINE_CTRL   8'h08
`define OFS_MODEM_CTRL  8'h0c
`define OFS_LINE_STAT   8'h10
`define OFS_MODEM_STAT  8'h14
`define OFS_DIV_LO      8'h18
`define OFS_DIV_HI      8'h1c

// Modem control fields
`define MC_TERM  0
`define MC_SEND  1
`define MC_AUXA  2
`define MC_AUXB  3
`define MC_LOOP  4

// Interrupt enable field
`define IE_MODEM 3

// Line status fields
`define LS_AVAIL 0
`define LS_OVFL  1

// Line control word length field
`define LC_LEN_HI 1
`define LC_LEN_LO 0

// Reset values
`define DIV_LO_RST  8'h01
`define DIV_HI_RST  8'h00
`define LC_RST      8'h03
`define MC_RST      8'h00
`define IE_RST      8'h00

// Receiver timing in 16x ticks, and data bit count limits
`define RX_MID_CNT  4'h7
`define RX_END_CNT  4'hf
`define RX_LAST_MIN 3'h4
`define RX_JUST_MAX 2'h3

`endif

// ==== pkg/serial_pkg.sv ====
package serial_pkg;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_e;

  // Active-low modem inputs, MSB first to match status bits 7..4
  typedef struct packed {
    logic carrier_n;
    logic alert_n;
    logic present_n;
    logic accepts_n;
  } modem_in_s;

  // Active-low modem control outputs
  typedef struct packed {
    logic aux_b_n;
    logic aux_a_n;
    logic send_n;
    logic term_n;
  } modem_out_s;

endpackage

// ==== design/serial_modem_status_rx_baud.sv ====
`include "serial_map.svh"

// How it works
// - Reading modem status clears the four change bits, live bits untouched.
// - During a status read new events wait and land at the read's end.
// - A set bit whose event recurs during the read clears at read end.
// - Change bits 0, 1 and 3 set when their modem input changes since the last read.
// - Alert-ended bit set by alert line change, never by a high-to-low edge.
// - Accepts-tx bit is inverted pin, or send request control in loop mode.
// - Set-present bit is inverted pin, or terminal-present control in loop mode.
// - Call-alert bit is inverted pin, or aux output A in loop mode.
// - Carrier-sense bit shows carrier input, or aux output B in loop mode.
// - Divider divides the clock by any 16-bit divisor from 1 to 65535.
// - Divider output runs at sixteen times the serial bit rate.
// - Writing either divisor byte reloads the 16-bit counter at once.
// - Receiver takes 5 to 8 data bits, right-justified from bit 0.
// - First data bit after start lands in bit 0.
// - Unused upper bits of a short character read as zero.
// - Data shifts on 16x ticks, phase restarted on each start bit.
// - Finished character loads the buffer and sets character-available.
// - Buffer holds one character while the next shifts in.
// - Unread buffer is overwritten by the next character, setting overflow.
// - Status bits 4..7 are live line states, one meaning pin low.
// - Modem interrupt enable plus any change bit raises the interrupt.
module serial_modem_status_rx_baud (
  input  wire logic                   CLK_I,
  input  wire logic                   RST_I,
  input  wire logic                   PSEL_I,
  input  wire logic                   PENABLE_I,
  input  wire logic                   PWRITE_I,
  input  wire logic [7:0]             PADDR_I,
  input  wire logic [31:0]            PWDATA_I,
  output logic      [31:0]            PRDATA_O,
  output logic                        PREADY_O,
  output logic                        PSLVERR_O,
  input  wire logic                   SERIAL_IN_I,
  input  wire serial_pkg::modem_in_s  MODEM_N_I,
  output serial_pkg::modem_out_s      MODEM_N_O,
  output logic                        MODEM_IRQ_O,
  output logic                        BAUD_TICK_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0]            div_lo_r;
  logic [7:0]            div_hi_r;
  logic [15:0]           baud_cnt_r;
  logic [15:0]           div_nxt;
  logic [7:0]            lc_r;
  logic [7:0]            mc_r;
  logic [7:0]            ie_r;
  logic [7:0]            rx_buf_r;
  logic                  avail_r;
  logic                  ovfl_r;
  logic [1:0]            ls_pend_r;
  logic [3:0]            delta_r;
  logic [3:0]            ms_pend_r;
  logic [3:0]            live_prev_r;
  logic                  primed_r;
  serial_pkg::rx_state_e rx_state_r;
  logic [3:0]            phase_r;
  logic [2:0]            bitn_r;
  logic [7:0]            shift_r;
  logic [3:0]            live;
  logic [3:0]            delta_ev;
  logic                  loop;
  logic                  tick;
  logic                  rx_line;
  logic                  rx_done;
  logic                  rx_restart;
  logic                  rx_sample;
  logic [2:0]            last_bit;
  logic                  setup;
  logic                  access;
  logic                  wr;
  logic                  div_wr;
  logic                  hit;
  logic                  ls_on;
  logic                  ls_end;
  logic                  ms_on;
  logic                  ms_end;
  logic                  rxb_end;
  logic [1:0]            ls_ev;
  logic [1:0]            ls_held;
  logic [1:0]            ls_pend_nxt;
  logic [3:0]            ms_held;
  logic [3:0]            ms_pend_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Status bit with read hold-off: returns {bit, pending}
  function automatic logic [1:0] held(input logic old, input logic ev, input logic pend,
                                      input logic on, input logic fin, input logic rd_clr);
    logic b;
    logic p;
    b = old | ev;
    p = 1'b0;
    if (fin) begin
      b = rd_clr ? (~old & (ev | pend)) : (old | ev | pend);
    end else if (on) begin
      b = old;
      p = pend | ev;
    end
    return {b, p};
  endfunction

  // Shift the assembled byte down to bit 0, zero filling above
  function automatic logic [7:0] justify(input logic [7:0] s, input logic [1:0] len);
    return s >> (`RX_JUST_MAX - len);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign setup     = PSEL_I & ~PENABLE_I;
  assign access    = PSEL_I & PENABLE_I;
  assign wr        = access & PWRITE_I;
  assign div_wr    = wr & ((PADDR_I == `OFS_DIV_LO) | (PADDR_I == `OFS_DIV_HI));
  assign ls_on     = PSEL_I & ~PWRITE_I & (PADDR_I == `OFS_LINE_STAT);
  assign ms_on     = PSEL_I & ~PWRITE_I & (PADDR_I == `OFS_MODEM_STAT);
  assign ls_end    = ls_on & PENABLE_I;
  assign ms_end    = ms_on & PENABLE_I;
  assign rxb_end   = access & ~PWRITE_I & (PADDR_I == `OFS_RX_BUF);
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = access & ~hit;

  always_comb begin
    case (PADDR_I)
      `OFS_RX_BUF, `OFS_INT_EN, `OFS_LINE_CTRL, `OFS_MODEM_CTRL,
      `OFS_LINE_STAT, `OFS_MODEM_STAT, `OFS_DIV_LO, `OFS_DIV_HI: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (setup) begin
      case (PADDR_I)
        `OFS_RX_BUF:     PRDATA_O <= {24'h00_0000, rx_buf_r};
        `OFS_INT_EN:     PRDATA_O <= {24'h00_0000, ie_r};
        `OFS_LINE_CTRL:  PRDATA_O <= {24'h00_0000, lc_r};
        `OFS_MODEM_CTRL: PRDATA_O <= {24'h00_0000, mc_r};
        `OFS_LINE_STAT:  PRDATA_O <= {30'h0000_0000, ovfl_r, avail_r};
        `OFS_MODEM_STAT: PRDATA_O <= {24'h00_0000, live, delta_r};
        `OFS_DIV_LO:     PRDATA_O <= {24'h00_0000, div_lo_r};
        `OFS_DIV_HI:     PRDATA_O <= {24'h00_0000, div_hi_r};
        default:         PRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lc_r <= `LC_RST;
      mc_r <= `MC_RST;
      ie_r <= `IE_RST;
    end else if (wr) begin
      case (PADDR_I)
        `OFS_LINE_CTRL:  lc_r <= PWDATA_I[7:0];
        `OFS_MODEM_CTRL: mc_r <= PWDATA_I[7:0];
        `OFS_INT_EN:     ie_r <= PWDATA_I[7:0];
        default:         ;
      endcase
    end
  end

  assign loop = mc_r[`MC_LOOP];

  // Modem control pins, forced inactive in loop mode
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      MODEM_N_O <= 4'hf;
    end else begin
      MODEM_N_O <= loop ? 4'hf : ~{mc_r[`MC_AUXB], mc_r[`MC_AUXA], mc_r[`MC_SEND], mc_r[`MC_TERM]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit rate divider

  always_comb begin
    div_nxt = {div_hi_r, div_lo_r};
    if (PADDR_I == `OFS_DIV_LO) begin
      div_nxt = {div_hi_r, PWDATA_I[7:0]};
    end else if (PADDR_I == `OFS_DIV_HI) begin
      div_nxt = {PWDATA_I[7:0], div_lo_r};
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      div_lo_r <= `DIV_LO_RST;
      div_hi_r <= `DIV_HI_RST;
    end else if (div_wr) begin
      div_lo_r <= div_nxt[7:0];
      div_hi_r <= div_nxt[15:8];
    end
  end

  assign tick        = (baud_cnt_r <= 16'h0001);
  assign BAUD_TICK_O = tick;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      baud_cnt_r <= {`DIV_HI_RST, `DIV_LO_RST};
    end else if (div_wr) begin
      baud_cnt_r <= div_nxt;
    end else if (tick) begin
      baud_cnt_r <= {div_hi_r, div_lo_r};
    end else begin
      baud_cnt_r <= baud_cnt_r - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver

  assign rx_line = loop ? 1'b1 : SERIAL_IN_I;
  assign rx_done    = tick & (rx_state_r == serial_pkg::RX_STOP) & (phase_r == `RX_END_CNT);
  assign rx_restart = ((rx_state_r == serial_pkg::RX_IDLE) & ~rx_line) |
                      ((rx_state_r == serial_pkg::RX_START) & (phase_r == `RX_MID_CNT));
  assign rx_sample  = tick & (rx_state_r == serial_pkg::RX_DATA) & (phase_r == `RX_END_CNT);
  assign last_bit   = `RX_LAST_MIN + {1'b0, lc_r[`LC_LEN_HI:`LC_LEN_LO]};

  // Receive sequencing
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_state_r <= serial_pkg::RX_IDLE;
    end else if (tick) begin
      case (rx_state_r)
        serial_pkg::RX_IDLE: begin
          if (!rx_line) begin
            rx_state_r <= serial_pkg::RX_START;
          end
        end
        serial_pkg::RX_START: begin
          if (phase_r == `RX_MID_CNT) begin
            rx_state_r <= rx_line ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
          end
        end
        serial_pkg::RX_DATA: begin
          if (rx_sample && (bitn_r == last_bit)) begin
            rx_state_r <= serial_pkg::RX_STOP;
          end
        end
        serial_pkg::RX_STOP: begin
          if (rx_done) begin
            rx_state_r <= serial_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state_r <= serial_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Sample phase, restarted at each start edge and at mid start
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      phase_r <= 4'h0;
    end else if (tick) begin
      if (rx_restart) begin
        phase_r <= 4'h0;
      end else begin
        phase_r <= phase_r + 4'h1;
      end
    end
  end

  // Data bit count
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bitn_r <= 3'h0;
    end else if (tick && (rx_state_r == serial_pkg::RX_START)) begin
      bitn_r <= 3'h0;
    end else if (rx_sample) begin
      bitn_r <= bitn_r + 3'h1;
    end
  end

  // Shifter, first bit ends up lowest
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      shift_r <= 8'h00;
    end else if (rx_sample) begin
      shift_r <= {rx_line, shift_r[7:1]};
    end
  end

  // Receive buffer, second stage behind the shifter
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_buf_r <= 8'h00;
    end else if (rx_done) begin
      rx_buf_r <= justify(shift_r, lc_r[`LC_LEN_HI:`LC_LEN_LO]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line status

  assign ls_ev[`LS_AVAIL] = rx_done;
  assign ls_ev[`LS_OVFL]  = rx_done & avail_r;

  always_comb begin
    {ls_held[`LS_AVAIL], ls_pend_nxt[`LS_AVAIL]} =
      held(avail_r, ls_ev[`LS_AVAIL], ls_pend_r[`LS_AVAIL], ls_on, ls_end, 1'b0);
    {ls_held[`LS_OVFL], ls_pend_nxt[`LS_OVFL]} =
      held(ovfl_r, ls_ev[`LS_OVFL], ls_pend_r[`LS_OVFL], ls_on, ls_end, 1'b1);
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      avail_r   <= 1'b0;
      ovfl_r    <= 1'b0;
      ls_pend_r <= 2'h0;
    end else begin
      avail_r   <= rxb_end ? rx_done : ls_held[`LS_AVAIL];
      ovfl_r    <= ls_held[`LS_OVFL];
      ls_pend_r <= ls_pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem status

  assign live = loop ? {mc_r[`MC_AUXB], mc_r[`MC_AUXA], mc_r[`MC_TERM], mc_r[`MC_SEND]} : ~MODEM_N_I;

  assign delta_ev[0] = primed_r & (live[0] ^ live_prev_r[0]);
  assign delta_ev[1] = primed_r & (live[1] ^ live_prev_r[1]);
  assign delta_ev[2] = primed_r & live_prev_r[2] & ~live[2];
  assign delta_ev[3] = primed_r & (live[3] ^ live_prev_r[3]);

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      {ms_held[i], ms_pend_nxt[i]} = held(delta_r[i], delta_ev[i], ms_pend_r[i], ms_on, ms_end, 1'b1);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      live_prev_r <= 4'h0;
      primed_r    <= 1'b0;
    end else begin
      live_prev_r <= live;
      primed_r    <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      delta_r   <= 4'h0;
      ms_pend_r <= 4'h0;
    end else begin
      delta_r   <= ms_held;
      ms_pend_r <= ms_pend_nxt;
    end
  end

  assign MODEM_IRQ_O = ie_r[`IE_MODEM] & (|delta_r);

endmodule

// ==== dv/serial_peer.sv ====
module serial_peer (
  input  wire logic             clk_i,
  input  wire logic             tick_i,
  output logic                  line_o,
  output serial_pkg::modem_in_s modem_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    line_o = 1'b1;
    modem_o = 4'hf;
  end

  task ticks(input int n);
    repeat (n) begin
      do @(posedge clk_i); while (tick_i !== 1'b1);
    end
  endtask

  task mdm(input logic [3:0] m);
    @(posedge clk_i);
    modem_o <= m;
  endtask

  // Start low, data least significant first, one stop bit high
  task send(input logic [7:0] c, input int n);
    line_o <= 1'b0;
    ticks(16);
    for (int i = 0; i < n; i++) begin
      line_o <= c[i];
      ticks(16);
    end
    line_o <= 1'b1;
    ticks(16);
  endtask
endmodule

// ==== dv/serial_chk.sv ====
`include "serial_map.svh"

module serial_chk (
  input wire logic                   CLK_I,
  input wire logic                   RST_I,
  input wire logic                   PSEL_I,
  input wire logic                   PENABLE_I,
  input wire logic                   PWRITE_I,
  input wire logic [7:0]             PADDR_I,
  input wire logic [31:0]            PWDATA_I,
  input wire logic [31:0]            PRDATA_O,
  input wire logic                   PREADY_O,
  input wire logic                   PSLVERR_O,
  input wire logic                   SERIAL_IN_I,
  input wire serial_pkg::modem_in_s  MODEM_N_I,
  input wire serial_pkg::modem_out_s MODEM_N_O,
  input wire logic                   MODEM_IRQ_O,
  input wire logic                   BAUD_TICK_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  logic [7:0]            ie_r, lc_r, mc_r, dlo_r, dhi_r;
  logic [16:0]           gap_r;
  logic                  dirty_r;
  logic [3:0]            stab_r;
  logic [7:0]            mcq_r;
  serial_pkg::modem_in_s mq_r;
  wire        wr = PSEL_I && PENABLE_I && PWRITE_I;
  wire        rds = PSEL_I && !PENABLE_I && !PWRITE_I;
  wire        rda = PSEL_I && PENABLE_I && !PWRITE_I;
  wire        lp = mc_r[`MC_LOOP];
  wire [16:0] div = ({dhi_r, dlo_r} == 16'h0) ? 17'h1 : {1'b0, dhi_r, dlo_r};
  wire [3:0]  live = lp ? {mc_r[`MC_AUXB], mc_r[`MC_AUXA], mc_r[`MC_TERM], mc_r[`MC_SEND]} : ~MODEM_N_I;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ie_r <= `IE_RST;
      lc_r <= `LC_RST;
      mc_r <= `MC_RST;
      dlo_r <= `DIV_LO_RST;
      dhi_r <= `DIV_HI_RST;
    end else if (wr) begin
      case (PADDR_I)
        `OFS_INT_EN: ie_r <= PWDATA_I[7:0];
        `OFS_LINE_CTRL: lc_r <= PWDATA_I[7:0];
        `OFS_MODEM_CTRL: mc_r <= PWDATA_I[7:0];
        `OFS_DIV_LO: dlo_r <= PWDATA_I[7:0];
        `OFS_DIV_HI: dhi_r <= PWDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // Cycles since the last tick or divisor write
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gap_r <= 17'h1;
      dirty_r <= 1'b1;
    end else if (wr && (PADDR_I == `OFS_DIV_LO || PADDR_I == `OFS_DIV_HI)) begin
      gap_r <= 17'h1;
      dirty_r <= 1'b1;
    end else if (BAUD_TICK_O) begin
      gap_r <= 17'h1;
      dirty_r <= 1'b0;
    end else begin
      gap_r <= gap_r + 17'h1;
    end
  end

  // Cycles since modem inputs or modem control last moved
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      stab_r <= 4'h0;
      mq_r <= 4'hf;
      mcq_r <= 8'h00;
    end else begin
      mq_r <= MODEM_N_I;
      mcq_r <= mc_r;
      if (MODEM_N_I != mq_r || mc_r != mcq_r) begin
        stab_r <= 4'h0;
      end else if (stab_r != 4'hf) begin
        stab_r <= stab_r + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_live;
    rds && PADDR_I == `OFS_MODEM_STAT && stab_r > 4'h3 |=> PRDATA_O[7:4] == $past(live);
  endproperty
  a_live: assert property (p_live) else $error("live modem bits wrong");
  property p_clr;
    rda && PADDR_I == `OFS_MODEM_STAT && stab_r > 4'h5 |=> !MODEM_IRQ_O;
  endproperty
  a_clr: assert property (p_clr) else $error("change bits not cleared by read");
  property p_irq;
    MODEM_IRQ_O |-> ie_r[`IE_MODEM];
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt while disabled");
  property p_rise;
    $rose(MODEM_IRQ_O) && $past(ie_r[`IE_MODEM]) |-> stab_r < 4'h8;
  endproperty
  a_rise: assert property (p_rise) else $error("change bit without input change");
  property p_period;
    BAUD_TICK_O && !dirty_r |-> gap_r == div;
  endproperty
  a_period: assert property (p_period) else $error("tick period differs from divisor");
  property p_reload;
    dirty_r |-> gap_r <= div + 17'h1;
  endproperty
  a_reload: assert property (p_reload) else $error("no early tick after divisor write");
  property p_upper;
    rds && PADDR_I == `OFS_RX_BUF |=> (PRDATA_O[7:0] >> (4'h5 + lc_r[1:0])) == 8'h00;
  endproperty
  a_upper: assert property (p_upper) else $error("unused character bits not zero");
  property p_loop;
    $stable(mc_r) |-> MODEM_N_O == (lp ? 4'hf : ~mc_r[3:0]);
  endproperty
  a_loop: assert property (p_loop) else $error("modem outputs wrong");
endmodule

bind serial_modem_status_rx_baud serial_chk i_serial_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .SERIAL_IN_I(SERIAL_IN_I), .MODEM_N_I(MODEM_N_I), .MODEM_N_O(MODEM_N_O),
  .MODEM_IRQ_O(MODEM_IRQ_O), .BAUD_TICK_O(BAUD_TICK_O));

// ==== dv/tb.sv ====
`include "serial_map.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  psel = 1'b0;
  logic                  pen = 1'b0;
  logic                  pwr = 1'b0;
  logic [7:0]            padr = 8'h00;
  logic [31:0]           pwd = 32'h0;
  logic [31:0]           prd;
  logic                  prdy;
  logic                  serial_in_pin;
  logic                  irq;
  logic                  tick;
  logic                  perr;
  logic                  err;
  logic [3:0]            mout;
  serial_pkg::modem_in_s mdm;
  logic [31:0]           d;
  int                    n_fail = 0;
  int                    checked = 0;
  int                    cyc = 0;
  int                    n;
  logic [7:0]            ra [6] = '{`OFS_DIV_LO, `OFS_DIV_HI, `OFS_LINE_CTRL, `OFS_MODEM_CTRL, `OFS_INT_EN, 8'h20};
  logic [7:0]            rv [6] = '{`DIV_LO_RST, `DIV_HI_RST, `LC_RST, `MC_RST, `IE_RST, 8'h00};

  always #2 clk = ~clk;

  serial_modem_status_rx_baud i_serial_modem_status_rx_baud (
    .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .SERIAL_IN_I(serial_in_pin), .MODEM_N_I(mdm), .MODEM_N_O(mout), .MODEM_IRQ_O(irq), .BAUD_TICK_O(tick));

  serial_peer i_serial_peer (.clk_i(clk), .tick_i(tick), .line_o(serial_in_pin), .modem_o(mdm));

  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task bus(input logic [7:0] a, input logic w, input logic [7:0] v);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= {24'h0, v};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    d = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    bus(a, 1'b1, v);
  endtask

  task rd(input logic [7:0] a);
    bus(a, 1'b0, 8'h00);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(d, {24'h0, rv[i]});
      chk(err, ra[i] == 8'h20);
    end
    $display("test registers done");
    wr(`OFS_DIV_HI, 8'h01);
    wr(`OFS_DIV_LO, 8'h00);
    n = 0;
    repeat (700) @(posedge clk) n = n + int'(tick);
    chk(n, 2);
    wr(`OFS_DIV_LO, 8'h03);
    wr(`OFS_DIV_HI, 8'h00);
    n = 0;
    repeat (60) @(posedge clk) n = n + int'(tick);
    chk(n, 20);
    wr(`OFS_DIV_LO, 8'h02);
    $display("test divisor done");
    i_serial_peer.mdm(4'b1110);
    rd(`OFS_MODEM_STAT);
    chk(d, 32'h11);
    rd(`OFS_MODEM_STAT);
    chk(d, 32'h10);
    i_serial_peer.mdm(4'b1010);
    rd(`OFS_MODEM_STAT);
    chk(d, 32'h50);
    i_serial_peer.mdm(4'b1110);
    rd(`OFS_MODEM_STAT);
    chk(d, 32'h14);
    i_serial_peer.mdm(4'b0100);
    rd(`OFS_MODEM_STAT);
    chk(d, 32'hba);
    fork
      rd(`OFS_MODEM_STAT);
      i_serial_peer.mdm(4'b0101);
    join
    chk(d, 32'ha0);
    rd(`OFS_MODEM_STAT);
    chk(d, 32'ha1);
    wr(`OFS_INT_EN, 8'h08);
    i_serial_peer.mdm(4'b1101);
    repeat (8) @(posedge clk);
    chk(irq, 1'b1);
    rd(`OFS_MODEM_STAT);
    chk(d, 32'h28);
    @(posedge clk);
    chk(irq, 1'b0);
    wr(`OFS_MODEM_CTRL, 8'h15);
    repeat (4) @(posedge clk);
    chk(mout, 32'hf);
    rd(`OFS_MODEM_STAT);
    chk(d & 32'hf0, 32'h60);
    wr(`OFS_MODEM_CTRL, 8'h1a);
    repeat (4) @(posedge clk);
    rd(`OFS_MODEM_STAT);
    chk(d & 32'hf0, 32'h90);
    wr(`OFS_MODEM_CTRL, 8'h05);
    repeat (2) @(posedge clk);
    chk(mout, 32'ha);
    $display("test modem done");
    for (int l = 0; l < 4; l++) begin
      wr(`OFS_LINE_CTRL, 8'(l));
      i_serial_peer.send(8'hd6, l + 5);
      rd(`OFS_LINE_STAT);
      chk(d, 32'h1);
      rd(`OFS_RX_BUF);
      chk(d, 32'hd6 & (32'hff >> (3 - l)));
    end
    i_serial_peer.send(8'h3c, 8);
    i_serial_peer.send(8'hc3, 8);
    rd(`OFS_LINE_STAT);
    chk(d, 32'h3);
    rd(`OFS_RX_BUF);
    chk(d, 32'hc3);
    rd(`OFS_LINE_STAT);
    chk(d, 32'h0);
    $display("test receive done");
    stop_test();
  end
endmodule
